// >>> csg_pkg.sv
// constants, offsets and types shared by the sequence guard config block
package csg_pkg;
    // word indices; byte address is four times the index
    localparam logic [7:0] IDX_DISCH_LOW   = 8'h0C;
    localparam logic [7:0] IDX_TRIG_CTRL   = 8'h0D;
    localparam logic [7:0] IDX_PRE_LOW     = 8'h0E;
    localparam logic [7:0] IDX_WARM_PREHI  = 8'h0F;
    localparam logic [7:0] IDX_FULL_LOW    = 8'h10;
    localparam logic [7:0] IDX_REF_FULLHI  = 8'h11;
    localparam logic [7:0] IDX_GUARD_CTRL  = 8'h12;
    localparam logic [7:0] IDX_GUARD_GAIN  = 8'h13;
    localparam logic [7:0] IDX_RDC_TRIM    = 8'h14;
    localparam logic [7:0] IDX_SEQ_CTRL    = 8'h18;
    localparam logic [7:0] IDX_SEQ_STATUS  = 8'h19;
    localparam int         CFG_REGS        = 9;

    // reset values: opcode trigger so nothing runs until software asks
    localparam logic [7:0] RST_TRIG_CTRL   = 8'h18;
    localparam logic [7:0] RST_CFG         = 8'h00;
    localparam logic [7:0] RST_TRIM        = 8'h07;

    // field positions
    localparam int POS_PIN_SEL   = 6;
    localparam int POS_TRIG_MODE = 2;
    localparam int POS_WARMUP    = 2;
    localparam int POS_REFCAP    = 2;
    localparam int POS_PULSED    = 7;
    localparam int POS_EXTERNAL  = 6;
    localparam int POS_GAIN      = 6;
    localparam int POS_RCY       = 7;
    localparam int POS_FAST_SEL  = 0;
    localparam int POS_SW_START  = 1;

    // phase value that switches a phase off
    localparam logic [9:0] PHASE_OFF = 10'h3FF;

    // guard switch-time step
    localparam int CLK_PERIOD_NS   = 20;
    localparam int GUARD_STEP_NS   = 500;
    localparam int GUARD_STEP_CYC  = (GUARD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // trigger modes
    typedef enum logic [2:0] {
        TRIG_CONT     = 3'b000,
        TRIG_READ     = 3'b001,
        TRIG_TIMER    = 3'b010,
        TRIG_STRETCH  = 3'b011,
        TRIG_UNDEF    = 3'b100,
        TRIG_PIN      = 3'b101,
        TRIG_OPCODE   = 3'b110,
        TRIG_CONT_EXP = 3'b111
    } csg_trig_t;

    // converter phases
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_DISCH = 3'b001,
        PH_PRECH = 3'b010,
        PH_FULL  = 3'b011,
        PH_DONE  = 3'b100
    } csg_phase_t;
endpackage

// >>> csg_sync.sv
// two-flop synchroniser for pin and oscillator levels
`timescale 1ns/10ps
module csg_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    // levels
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } csg_sync_st_t;

    csg_sync_st_t q;
    csg_sync_st_t d;

    // stage1 is read by stage2 only
    always_comb
    begin
        d        = q;
        d.stage1 = asyncIn;
        d.stage2 = q.stage1;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            q <= '0;
        else
            q <= d;
    end

    assign syncOut = q.stage2;
endmodule // csg_sync

// >>> csg_seq_guard.sv
// config bank, phase sequencer and guard control of the capacitance converter
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/10ps
module csg_seq_guard (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // oscillators, pins and triggers
    input  wire logic        slowOscillator,
    input  wire logic        fastOscillator,
    input  wire logic [3:0]  gpioPin,
    input  wire logic        timerTrigger,
    // converter control
    output logic      [2:0]  convPhase,
    output logic             resultValid,
    output logic             fakeActive,
    output logic      [4:0]  refCapCode,
    output logic             resistiveCycleTimeSelect,
    // guard control
    output logic      [5:0]  guardPortEnable,
    output logic             shieldAmpOn,
    output logic             shieldAmpExternal,
    output logic      [1:0]  shieldAmpGain,
    output logic      [2:0]  shieldAmpCurrentTrim,
    output logic             guardDirect,
    output logic             shieldMuxSelectOut,
    output logic             shieldMuxSelectOe
);
    typedef struct packed {
        logic [csg_pkg::CFG_REGS-1:0][7:0] cfg;
        logic                fastSel;
        logic                swStart;
        logic                wrPend;
        logic [7:0]          wrIdx;
        logic [31:0]         rdata;
        logic                ready;
        logic                resp;
        csg_pkg::csg_phase_t phase;
        logic [10:0]         cnt;
        logic [8:0]          gcnt;
        logic [8:0]          gdRun;
        logic [3:0]          fakeLeft;
        logic [3:0]          pinPrev;
        logic                slowPrev;
        logic                fastPrev;
        logic                guardDirect;
        logic                ampOn;
        logic [5:0]          guardEn;
        logic                muxOut;
        logic                muxOe;
        logic                resultValid;
        logic                fakeActive;
    } csg_state_t;

    csg_state_t q;
    csg_state_t d;

    logic [3:0] pinSync;
    logic [1:0] oscSync;

    csg_sync #(.W(6)) uSync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .asyncIn ({fastOscillator, slowOscillator, gpioPin}),
        .syncOut ({oscSync, pinSync})
    );

    // decoded fields
    logic [9:0]          dischVal;
    logic [9:0]          preVal;
    logic [9:0]          fullVal;
    logic [10:0]         dischCnt;
    logic [10:0]         preCnt;
    logic [10:0]         fullCnt;
    logic [8:0]          guardLoad;
    logic [3:0]          warmup;
    logic [1:0]          pinSel;
    csg_pkg::csg_trig_t  trigMode;
    logic [3:0]          pinRise;
    logic                tick;
    logic                access;
    logic [7:0]          idx;
    logic                rdStatus;
    logic                startReq;

    always_comb
    begin
        dischVal = {q.cfg[1][1:0], q.cfg[0]};
        preVal   = {q.cfg[3][1:0], q.cfg[2]};
        fullVal  = {q.cfg[5][1:0], q.cfg[4]};
        warmup   = q.cfg[3][csg_pkg::POS_WARMUP +: 4];
        pinSel   = q.cfg[1][csg_pkg::POS_PIN_SEL +: 2];
        trigMode = csg_pkg::csg_trig_t'(q.cfg[1][csg_pkg::POS_TRIG_MODE +: 3]);
        // fast oscillator drops the +1 on discharge, adds one more on fullcharge, or on precharge when fullcharge is off
        if (dischVal == csg_pkg::PHASE_OFF)
            dischCnt = 11'h000;
        else if (q.fastSel)
            dischCnt = {1'b0, dischVal};
        else
            dischCnt = {1'b0, dischVal} + 11'h001;
        if (preVal == csg_pkg::PHASE_OFF)
            preCnt = 11'h000;
        else if (q.fastSel && fullVal == csg_pkg::PHASE_OFF)
            preCnt = {1'b0, preVal} + 11'h002;
        else
            preCnt = {1'b0, preVal} + 11'h001;
        if (fullVal == csg_pkg::PHASE_OFF)
            fullCnt = 11'h000;
        else if (q.fastSel)
            fullCnt = {1'b0, fullVal} + 11'h002;
        else
            fullCnt = {1'b0, fullVal} + 11'h001;
        guardLoad = 9'(q.cfg[7][3:0] * csg_pkg::GUARD_STEP_CYC);
        pinRise   = pinSync & ~q.pinPrev;
        // rising edge of the selected oscillator is one cycle-clock period
        tick      = q.fastSel ? (oscSync[1] & ~q.fastPrev)
                              : (oscSync[0] & ~q.slowPrev);
        access    = hsel & htrans[1] & hready;
        idx       = haddr[9:2];
        rdStatus  = access & ~hwrite & (idx == csg_pkg::IDX_SEQ_STATUS);
        case (trigMode)
            csg_pkg::TRIG_CONT:     startReq = 1'b1;
            csg_pkg::TRIG_CONT_EXP: startReq = 1'b1;
            csg_pkg::TRIG_READ:     startReq = rdStatus;
            csg_pkg::TRIG_TIMER:    startReq = timerTrigger;
            csg_pkg::TRIG_STRETCH:  startReq = timerTrigger;
            csg_pkg::TRIG_PIN:      startReq = pinRise[pinSel];
            csg_pkg::TRIG_OPCODE:   startReq = q.swStart;
            default:                startReq = 1'b0;
        endcase
    end

    always_comb
    begin
        d          = q;
        d.pinPrev  = pinSync;
        d.slowPrev = oscSync[0];
        d.fastPrev = oscSync[1];
        d.swStart  = 1'b0;
        d.ready    = 1'b1;
        d.resp     = 1'b0;
        d.resultValid = 1'b0;

        // bus: address phase captured, write lands in the data phase
        d.wrPend = access & hwrite;
        d.wrIdx  = idx;
        if (access & ~hwrite)
        begin
            d.rdata = 32'h0000_0000;
            if (idx >= csg_pkg::IDX_DISCH_LOW && idx <= csg_pkg::IDX_RDC_TRIM)
                d.rdata[7:0] = q.cfg[4'(idx - csg_pkg::IDX_DISCH_LOW)];
            else if (idx == csg_pkg::IDX_SEQ_CTRL)
                d.rdata[csg_pkg::POS_FAST_SEL] = q.fastSel;
            else if (idx == csg_pkg::IDX_SEQ_STATUS)
                d.rdata[7:0] = {q.fakeLeft, q.fakeActive, q.phase};
        end
        if (q.wrPend)
        begin
            if (q.wrIdx >= csg_pkg::IDX_DISCH_LOW && q.wrIdx <= csg_pkg::IDX_RDC_TRIM)
                d.cfg[4'(q.wrIdx - csg_pkg::IDX_DISCH_LOW)] = hwdata[7:0];
            else if (q.wrIdx == csg_pkg::IDX_SEQ_CTRL)
            begin
                d.fastSel = hwdata[csg_pkg::POS_FAST_SEL];
                d.swStart = hwdata[csg_pkg::POS_SW_START];
            end
        end

        // phase sequencer; a zero count leaves its phase after one clock
        case (q.phase)
            csg_pkg::PH_IDLE:
            begin
                if (startReq)
                begin
                    d.phase    = csg_pkg::PH_DISCH;
                    d.cnt      = dischCnt;
                    d.fakeLeft = warmup;
                end
            end
            csg_pkg::PH_DISCH:
            begin
                if (q.cnt == 11'h000)
                begin
                    d.phase = csg_pkg::PH_PRECH;
                    d.cnt   = preCnt;
                    d.gcnt  = guardLoad;
                end
                else if (tick)
                    d.cnt = q.cnt - 11'h001;
            end
            csg_pkg::PH_PRECH:
            begin
                if (q.gcnt != 9'h000)
                    d.gcnt = q.gcnt - 9'h001;
                if (q.cnt == 11'h000)
                begin
                    d.phase = csg_pkg::PH_FULL;
                    d.cnt   = fullCnt;
                end
                else if (tick)
                    d.cnt = q.cnt - 11'h001;
            end
            csg_pkg::PH_FULL:
            begin
                if (q.cnt == 11'h000)
                    d.phase = csg_pkg::PH_DONE;
                else if (tick)
                    d.cnt = q.cnt - 11'h001;
            end
            csg_pkg::PH_DONE:
            begin
                if (q.fakeLeft != 4'h0)
                begin
                    d.fakeLeft = q.fakeLeft - 4'h1;
                    d.phase    = csg_pkg::PH_DISCH;
                    d.cnt      = dischCnt;
                end
                else
                begin
                    d.resultValid = 1'b1;
                    d.phase       = csg_pkg::PH_IDLE;
                end
            end
            default:
                d.phase = csg_pkg::PH_IDLE;
        endcase

        // warm-up results never raise resultValid
        d.fakeActive  = (d.fakeLeft != 4'h0) && (d.phase != csg_pkg::PH_IDLE);
        d.guardDirect = (d.phase == csg_pkg::PH_PRECH) && (d.gcnt != 9'h000);
        d.gdRun       = q.guardDirect ? q.gdRun + 9'h001 : 9'h000;
        d.guardEn     = q.cfg[6][5:0];
        // pulsed mode sleeps the amplifier whenever no conversion runs
        d.ampOn       = ~q.cfg[6][csg_pkg::POS_PULSED] |
                        (d.phase != csg_pkg::PH_IDLE);
        d.muxOe       = q.cfg[6][csg_pkg::POS_EXTERNAL];
        d.muxOut      = q.cfg[6][csg_pkg::POS_EXTERNAL] & ~d.guardDirect;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q        <= '0;
            q.cfg[1] <= csg_pkg::RST_TRIG_CTRL;
            q.cfg[8] <= csg_pkg::RST_TRIM;
            q.ready  <= 1'b1;
        end
        else
            q <= d;
    end

    assign hrdata                   = q.rdata;
    assign hreadyout                = q.ready;
    assign hresp                    = q.resp;
    assign convPhase                = q.phase;
    assign resultValid              = q.resultValid;
    assign fakeActive               = q.fakeActive;
    assign refCapCode               = q.cfg[5][csg_pkg::POS_REFCAP +: 5];
    assign resistiveCycleTimeSelect = q.cfg[8][csg_pkg::POS_RCY];
    assign guardPortEnable          = q.guardEn;
    assign shieldAmpOn              = q.ampOn;
    assign shieldAmpExternal        = q.cfg[6][csg_pkg::POS_EXTERNAL];
    assign shieldAmpGain            = q.cfg[7][csg_pkg::POS_GAIN +: 2];
    assign shieldAmpCurrentTrim     = q.cfg[8][2:0];
    assign guardDirect              = q.guardDirect;
    assign shieldMuxSelectOut       = q.muxOut;
    assign shieldMuxSelectOe        = q.muxOe;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_enter_prech;
        q.phase == csg_pkg::PH_DISCH ##1 q.phase == csg_pkg::PH_PRECH;
    endsequence

    property p_pin_start;
        q.phase == csg_pkg::PH_IDLE && trigMode == csg_pkg::TRIG_PIN && pinRise[pinSel]
            |=> q.phase == csg_pkg::PH_DISCH;
    endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin start missed");

    property p_undef_mode;
        q.phase == csg_pkg::PH_IDLE && trigMode == csg_pkg::TRIG_UNDEF
            |=> q.phase == csg_pkg::PH_IDLE;
    endproperty
    a_undef_mode: assert property (p_undef_mode) else $error("mode 4 started");

    property p_disch_skip;
        q.phase == csg_pkg::PH_IDLE && startReq && dischVal == csg_pkg::PHASE_OFF
            ##1 $stable(q.cfg) |=> q.phase == csg_pkg::PH_PRECH;
    endproperty
    a_disch_skip: assert property (p_disch_skip) else $error("discharge not skipped");

    property p_pre_load;
        s_enter_prech |-> q.cnt == $past(preCnt);
    endproperty
    a_pre_load: assert property (p_pre_load) else $error("precharge count wrong");

    property p_full_load;
        q.phase == csg_pkg::PH_PRECH ##1 q.phase == csg_pkg::PH_FULL
            |-> q.cnt == $past(fullCnt);
    endproperty
    a_full_load: assert property (p_full_load) else $error("fullcharge count wrong");

    // a short precharge cuts the guard time; only a fall inside precharge is timed
    sequence s_guard_fall;
        guardDirect ##1 !guardDirect && q.phase == csg_pkg::PH_PRECH;
    endsequence

    property p_guard_direct;
        s_guard_fall |-> q.gdRun == 9'(q.cfg[7][3:0] * csg_pkg::GUARD_STEP_CYC);
    endproperty
    a_guard_direct: assert property (p_guard_direct) else $error("guard time wrong");

    property p_amp_perm;
        !q.cfg[6][csg_pkg::POS_PULSED] |=> shieldAmpOn;
    endproperty
    a_amp_perm: assert property (p_amp_perm) else $error("amplifier slept");

    property p_ext_mux;
        q.cfg[6][csg_pkg::POS_EXTERNAL] |=> shieldMuxSelectOe;
    endproperty
    a_ext_mux: assert property (p_ext_mux) else $error("mux pin not driven");

    property p_guard_en;
        ##1 guardPortEnable == $past(q.cfg[6][5:0]);
    endproperty
    a_guard_en: assert property (p_guard_en) else $error("guard enable wrong");

    property p_fake_count;
        resultValid |-> $past(q.phase) == csg_pkg::PH_DONE && !fakeActive;
    endproperty
    a_fake_count: assert property (p_fake_count) else $error("warm-up counted");
endmodule // csg_seq_guard

// >>> tb_top.sv
// self-checking testbench of the sequence guard config block
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
    } csg_row_t;

    // clock, reset and bus
    logic        ref_clk      = 1'b0;
    logic        resetn       = 1'b0;
    logic        hsel         = 1'b0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [2:0]  hsize        = 3'h0;
    logic [31:0] hwdata       = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    // pins and oscillators: slow is clk/8, fast is clk/4
    logic [7:0]  oscCnt       = 8'h0;
    logic [3:0]  gpioPin      = 4'h0;
    logic        timerTrigger = 1'b0;
    // outputs
    logic [2:0]  convPhase;
    logic        resultValid;
    logic        fakeActive;
    logic [4:0]  refCapCode;
    logic        rcySel;
    logic [5:0]  guardPortEnable;
    logic        shieldAmpOn;
    logic        shieldAmpExternal;
    logic [1:0]  shieldAmpGain;
    logic [2:0]  shieldAmpCurrentTrim;
    logic        guardDirect;
    logic        shieldMuxSelectOut;
    logic        shieldMuxSelectOe;
    // bookkeeping
    int          errTotal;
    int          samplesChecked;
    int          cyc [5];
    int          rv;
    int          fk;
    int          gd;
    int          ampOff;
    csg_row_t    rows [9] = '{
        '{8'h0C, 8'hA5, 8'hA5}, '{8'h0E, 8'h3C, 8'h3C}, '{8'h0F, 8'h3D, 8'h3D},
        '{8'h10, 8'hFF, 8'hFF}, '{8'h11, 8'h7E, 8'h7E}, '{8'h12, 8'h6A, 8'h6A},
        '{8'h13, 8'hCF, 8'hCF}, '{8'h14, 8'h85, 8'h85}, '{8'h0D, 8'hD7, 8'hD7}};
    // reset image: opcode mode, trim 7, everything else clear
    logic [7:0]  rIdx [11] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
                               8'h13, 8'h14, 8'h18, 8'h19};
    logic [7:0]  rRst [11] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h07, 8'h00, 8'h00};

    assign hready = hreadyout;

    always #10 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
        oscCnt <= oscCnt + 8'h1;

    csg_seq_guard dut (
        .ref_clk                  (ref_clk),
        .resetn                   (resetn),
        .hsel                     (hsel),
        .haddr                    (haddr),
        .htrans                   (htrans),
        .hwrite                   (hwrite),
        .hsize                    (hsize),
        .hwdata                   (hwdata),
        .hready                   (hready),
        .hrdata                   (hrdata),
        .hreadyout                (hreadyout),
        .hresp                    (hresp),
        .slowOscillator           (oscCnt[2]),
        .fastOscillator           (oscCnt[1]),
        .gpioPin                  (gpioPin),
        .timerTrigger             (timerTrigger),
        .convPhase                (convPhase),
        .resultValid              (resultValid),
        .fakeActive               (fakeActive),
        .refCapCode               (refCapCode),
        .resistiveCycleTimeSelect (rcySel),
        .guardPortEnable          (guardPortEnable),
        .shieldAmpOn              (shieldAmpOn),
        .shieldAmpExternal        (shieldAmpExternal),
        .shieldAmpGain            (shieldAmpGain),
        .shieldAmpCurrentTrim     (shieldAmpCurrentTrim),
        .guardDirect              (guardDirect),
        .shieldMuxSelectOut       (shieldMuxSelectOut),
        .shieldMuxSelectOe        (shieldMuxSelectOe)
    );

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e)
        begin
            errTotal++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // phase lengths: the first oscillator tick lands anywhere in one period
    task automatic near(input string nm, input int e, input int g, input int tol);
        samplesChecked++;
        if (g < e - tol || g > e + tol)
        begin
            errTotal++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        ahb(1'b1, idx, v, d);
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] d;
        ahb(1'b0, idx, 8'h0, d);
        chk($sformatf("reg %h", idx), {24'h0, e}, d);
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        while (convPhase !== 3'h0 && n < 5000)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("idle", 32'h0, {29'h0, convPhase});
    endtask

    task automatic mon();
        int n;
        cyc = '{default: 0};
        rv = 0;
        fk = 0;
        gd = 0;
        ampOff = 0;
        n = 0;
        while (rv == 0 && n < 20000)
        begin
            @(posedge ref_clk);
            #1;
            n++;
            if (convPhase < 3'h5) cyc[convPhase]++;
            if (resultValid === 1'b1) rv++;
            if (fakeActive === 1'b1) fk++;
            if (guardDirect === 1'b1) gd++;
            if (convPhase !== 3'h0 && shieldAmpOn !== 1'b1) ampOff++;
        end
    endtask

    task automatic cfg(input logic [9:0] dv, input logic [9:0] pv, input logic [9:0] fv,
                       input logic [3:0] w, input logic [7:0] g);
        wr(8'h0C, dv[7:0]);
        wr(8'h0D, {3'h0, 3'h6, dv[9:8]});
        wr(8'h0E, pv[7:0]);
        wr(8'h0F, {2'h0, w, pv[9:8]});
        wr(8'h10, fv[7:0]);
        wr(8'h11, {6'h0, fv[9:8]});
        wr(8'h12, g);
    endtask

    // n values are cycle ticks per phase, p the oscillator period in clocks
    task automatic durChk(input int w, input int p, input int nd, input int np, input int nf);
        near("discharge", (w + 1) * (nd * p + 1), cyc[1], (nd > 0) ? (w + 1) * p : 0);
        near("precharge", (w + 1) * (np * p + 1), cyc[2], (np > 0) ? (w + 1) * p : 0);
        near("fullcharge", (w + 1) * (nf * p + 1), cyc[3], (nf > 0) ? (w + 1) * p : 0);
        chk("resultValid", 32'h1, rv);
        chk("guardDirect", (w + 1) * 25, gd);
    endtask

    initial
    begin
        #(90000 * 20);
        errTotal++;
        $display("[FAIL] watchdog expired");
        endOfTest();
    end

    initial
    begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("trim", 32'h7, {29'h0, shieldAmpCurrentTrim});
        for (int i = 0; i < 11; i++) rdChk(rIdx[i], rRst[i]);
        chk("ampOn", 32'h1, {31'h0, shieldAmpOn});
        // every trigger code, while all times are still short
        for (int m = 0; m < 8; m++) rdChkMode(m);
        wr(8'h0D, 8'h18);
        waitIdle();
        for (int i = 0; i < 9; i++)
        begin
            wr(rows[i].idx, rows[i].wd);
            rdChk(rows[i].idx, rows[i].rd);
        end
        chk("refCap", 32'h1F, {27'h0, refCapCode});
        chk("guardEn", 32'h2A, {26'h0, guardPortEnable});
        chk("ampExt", 32'h1, {31'h0, shieldAmpExternal});
        chk("muxOe", 32'h1, {31'h0, shieldMuxSelectOe});
        chk("muxOut", 32'h1, {31'h0, shieldMuxSelectOut});
        chk("gain", 32'h3, {30'h0, shieldAmpGain});
        chk("trim", 32'h5, {29'h0, shieldAmpCurrentTrim});
        chk("rcy", 32'h1, {31'h0, rcySel});
        // slow clock, discharge high bits set, warm-up off
        cfg(10'h102, 10'h005, 10'h002, 4'h0, 8'h3F);
        wr(8'h13, 8'h01);
        wr(8'h14, 8'h07);
        wr(8'h18, 8'h02);
        mon();
        durChk(0, 8, 259, 6, 3);
        chk("noFake", 32'h0, fk);
        // discharge off, two warm-ups, pulsed amplifier
        cfg(10'h3FF, 10'h005, 10'h002, 4'h2, 8'hBF);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("ampSleep", 32'h0, {31'h0, shieldAmpOn});
        wr(8'h18, 8'h02);
        mon();
        durChk(2, 8, 0, 6, 3);
        chk("fakeSeen", 32'h1, {31'h0, fk > 0});
        chk("ampAwake", 32'h0, ampOff);
        // fast clock with fullcharge off, then with fullcharge on
        cfg(10'h003, 10'h005, 10'h3FF, 4'h0, 8'h3F);
        wr(8'h18, 8'h03);
        mon();
        durChk(0, 4, 3, 7, 0);
        cfg(10'h001, 10'h007, 10'h002, 4'h0, 8'h3F);
        wr(8'h18, 8'h03);
        mon();
        durChk(0, 4, 1, 8, 4);
        // pin mode on pin 2: pin 1 must not start it
        wr(8'h18, 8'h00);
        wr(8'h0D, 8'h94);
        @(posedge ref_clk);
        gpioPin <= 4'h2;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("pinIgnored", 32'h0, {29'h0, convPhase});
        @(posedge ref_clk);
        gpioPin <= 4'h6;
        mon();
        chk("pinStart", 32'h1, rv);
        gpioPin <= 4'h0;
        // timer mode
        wr(8'h0D, 8'h08);
        @(posedge ref_clk);
        timerTrigger <= 1'b1;
        @(posedge ref_clk);
        timerTrigger <= 1'b0;
        mon();
        chk("timerStart", 32'h1, rv);
        // read-triggered mode starts on a status read
        wr(8'h0D, 8'h04);
        rdStatus();
        mon();
        chk("readStart", 32'h1, rv);
        // unmapped word ignores writes and reads zero
        wr(8'h0D, 8'h18);
        wr(8'h30, 8'h55);
        rdChk(8'h30, 8'h00);
        // reset in mid-conversion
        cfg(10'h0FF, 10'h005, 10'h002, 4'h0, 8'h3F);
        wr(8'h18, 8'h02);
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("rstPhase", 32'h0, {29'h0, convPhase});
        chk("rstTrim", 32'h7, {29'h0, shieldAmpCurrentTrim});
        @(posedge ref_clk);
        resetn <= 1'b1;
        rdChk(8'h0E, 8'h00);
        endOfTest();
    end

    task automatic rdChkMode(input int m);
        wr(8'h0D, 8'(m << 2));
        rdChk(8'h0D, 8'(m << 2));
    endtask

    task automatic rdStatus();
        logic [31:0] d;
        ahb(1'b0, 8'h19, 8'h0, d);
    endtask
endmodule // tb_top
